// file: rtl/npgc_port.sv
// Full-duplex nibble port with receive gain loading logic.
`timescale 1ns/1ps
`default_nettype none
module npgc_port
	import npgc_pkg::*;
(
	// System clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register access from the serial engine
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWdata,
	output logic [7:0] regRdata,
	// Strap and clock sources
	input wire logic modeSelect,
	input wire logic nibbleClk,
	input wire logic oscInput,
	// Nibble port pins
	output logic sharedPortClock,
	input wire logic [5:0] txNibbleBus,
	input wire logic txWordPhase,
	input wire logic gainStrobe,
	input wire logic txMute_n,
	output logic [5:0] rxNibbleBus,
	output logic rxBusOe,
	output logic rxWordPhase,
	// Direct gain pins
	input wire logic [5:0] directGainBus,
	// Converter side, link domain
	input wire logic [9:0] rxSample,
	output logic [9:0] txWord,
	output logic txWordValid,
	// Gain and configuration outputs, system domain
	output logic [5:0] rxGainCode,
	output logic [5:0] txGainCode,
	output logic [1:0] interpFactor,
	output logic lowDrive
);

	// Register-domain, link-domain and falling-edge state
	npgc_sys_state_t sys, next_sys;
	npgc_link_state_t link, next_link;
	npgc_neg_state_t neg, next_neg;
	npgc_link_cfg_t sysCfg; // Bundle handed across to the link domain
	logic linkReset; // Reset as seen by the link domain
	logic gainEvent; // Port gain load arrived from link domain
	logic spiGainWrite; // Enabled software write of the gain code
	logic [5:0] spiGainValue; // Gain field of the write data
	logic [5:0] directMapped; // Direct bus after optional coarse map
	logic clkSource; // Selected port clock source
	logic [5:0] txNib; // Tx nibble at the selected edge
	logic txPh; // Tx phase at the selected edge
	logic txStrobeEff; // Pin or software gain strobe
	logic txGainMode; // Cycle belongs to a gain load
	logic txIsFirst; // Nibble is the first of a word
	logic txDataCycle; // Cycle feeds the interpolator path

	// Convert between straight binary and twos complement (self-inverse)
	function automatic logic [9:0] fmtWord(input logic [9:0] w, input logic binary);
		fmtWord = binary ? (w ^ SIGN_FLIP) : w;
	endfunction

	// Join first and second nibbles into one word
	function automatic logic [9:0] joinNibbles(input logic [5:0] first, input logic [5:0] second,
		input logic five, input logic lsFirst);
		logic [5:0] ms;
		logic [5:0] ls;
		ms = lsFirst ? second : first;
		ls = lsFirst ? first : second;
		// Five-bit nibbles use lines 5:1, line 0 is dropped
		joinNibbles = five ? {ms[5:1], ls[5:1]} : {ms, ls[3:0]};
	endfunction

	// Pick the MS or LS part of a word as a bus nibble
	function automatic logic [5:0] splitNibble(input logic [9:0] w, input logic five,
		input logic msPart);
		if (five)
		begin
			splitNibble = msPart ? {w[9:5], 1'b0} : {w[4:0], 1'b0};
		end
		else
		begin
			splitNibble = msPart ? w[9:4] : {2'b00, w[3:0]};
		end
	endfunction

	// Coarse three-bit map: 000 and 001 give the floor, then 8 dB per code
	function automatic logic [5:0] coarseMap(input logic [2:0] c);
		coarseMap = (c < 3'h2) ? GAIN_MIN : {c - 3'h1, 3'h0};
	endfunction

	// Port clock: source select, invert, disable. A glitch can appear when
	// these bits change while running; software changes them only when idle.
	always_comb
	begin
		clkSource = sys.portClk[PCLK_OSC_BIT] ? oscInput : nibbleClk;
		// Master clock out, continuous unless disabled
		sharedPortClock = sys.portClk[PCLK_DISABLE_BIT] ? 1'b0
			: (clkSource ^ sys.portClk[PCLK_INVERT_BIT]);
	end

	// Configuration bundle built from register flops only. It crosses two
	// stages and the link adopts it only once two later samples agree, so a
	// bundle caught in mid-change is never used; the cost is two more clocks.
	always_comb
	begin
		sysCfg.fullDuplex = sys.fullDuplex;
		sysCfg.gainOnTx = sys.gainSrc[SRC_TXPORT_BIT];
		sysCfg.swStrobe = sys.gainSrc[SRC_SWSTROBE_BIT];
		sysCfg.txCfg = sys.txCfg;
		sysCfg.rxCfg = sys.rxCfg;
	end

	// Register-domain next state: synchronisers, register file, gain sources
	always_comb
	begin
		next_sys = sys;
		// Strap and direct gain pins pass two flops
		next_sys.modeMeta = modeSelect;
		next_sys.fullDuplex = sys.modeMeta;
		next_sys.directMeta = directGainBus;
		next_sys.direct = sys.directMeta;
		// Toggle crossing of port gain loads
		next_sys.togMeta = link.gainToggle;
		next_sys.togSync = sys.togMeta;
		next_sys.togSeen = sys.togSync;
		gainEvent = sys.togSync ^ sys.togSeen;
		spiGainValue = regWdata[GAIN_W-1:0];
		spiGainWrite = regWrite && (regAddr == ADDR_RX_GAIN) && regWdata[GAIN_SPI_EN_BIT];
		directMapped = sys.gainSrc[SRC_MAP3_BIT] ? coarseMap(sys.direct[5:3]) : sys.direct;
		// Lowest priority: direct bus passes without strobe
		if (sys.gainSrc[SRC_DIRECT_RX_BIT])
		begin
			next_sys.rxGain = directMapped;
		end
		if (sys.gainSrc[SRC_DIRECT_TX_BIT])
		begin
			next_sys.txGain = sys.direct;
		end
		// Port gain load; data stays stable in the link flops while crossing
		if (gainEvent && sys.fullDuplex)
		begin
			next_sys.rxGain = link.gainCapture;
		end
		// Register writes take highest priority
		if (regWrite)
		begin
			case (regAddr)
				ADDR_PORT_CLOCK: next_sys.portClk = regWdata & PORT_CLOCK_MASK;
				ADDR_RX_GAIN:
				begin
					next_sys.rxGainSpiEn = regWdata[GAIN_SPI_EN_BIT];
					if (spiGainWrite)
					begin
						next_sys.rxGain = spiGainValue;
					end
				end
				ADDR_GAIN_SRC: next_sys.gainSrc = regWdata;
				ADDR_TX_CFG:
				begin
					next_sys.txCfg = regWdata;
					// Bypass and reserved factors refused in full duplex
					if (sys.fullDuplex && ((regWdata[7:6] == INTERP_X1)
						|| (regWdata[7:6] == INTERP_RSVD)))
					begin
						next_sys.txCfg[7:6] = sys.txCfg[7:6];
					end
				end
				ADDR_RX_CFG: next_sys.rxCfg = regWdata;
				ADDR_DRIVE: next_sys.drive = regWdata;
				default: next_sys.rdata = sys.rdata;
			endcase
		end
		// Read answer one cycle later; unmapped reads give zero
		if (regRead)
		begin
			case (regAddr)
				ADDR_PORT_CLOCK: next_sys.rdata = sys.portClk;
				ADDR_RX_GAIN: next_sys.rdata = {1'b0, sys.rxGainSpiEn,
					sys.rxGainSpiEn ? sys.rxGain : GAIN_MIN};
				ADDR_GAIN_SRC: next_sys.rdata = sys.gainSrc;
				ADDR_TX_CFG: next_sys.rdata = sys.txCfg;
				ADDR_RX_CFG: next_sys.rdata = sys.rxCfg;
				ADDR_DRIVE: next_sys.rdata = sys.drive;
				default: next_sys.rdata = 8'h00;
			endcase
		end
		// Synchronous reset: gain at minimum, defaults everywhere
		if (reset)
		begin
			next_sys = '0;
			next_sys.portClk = PORT_CLOCK_RESET;
			next_sys.gainSrc = GAIN_SRC_RESET;
			next_sys.txCfg = PORT_CFG_RESET;
			next_sys.rxCfg = PORT_CFG_RESET;
			next_sys.drive = DRIVE_RESET;
			next_sys.rxGain = GAIN_MIN;
			next_sys.txGain = GAIN_MIN;
		end
	end

	// Register-domain flops
	always_ff @(posedge clk_sys)
	begin
		sys <= next_sys;
	end

	// Falling-edge capture of tx pins and launch of rx nibbles
	always_comb
	begin
		next_neg.txNibble = txNibbleBus;
		next_neg.txPhase = txWordPhase;
		next_neg.strobe = gainStrobe;
		next_neg.rxNibble = link.rxNibble;
		next_neg.rxPhase = link.rxPhase;
	end

	// Falling-edge flops; only used when a bus selects the negative edge
	always_ff @(negedge nibbleClk)
	begin
		neg <= next_neg;
	end

	assign linkReset = link.rstSync[1];

	// Link-domain next state: tx word assembly, gain capture, rx nibbles
	always_comb
	begin
		next_link = link;
		next_link.rstSync = {link.rstSync[0], reset};
		next_link.cfgMeta = sysCfg;
		next_link.cfgSync = link.cfgMeta;
		next_link.cfgPrev = link.cfgSync;
		// Bundle taken only when two samples agree, never a skewed mix
		if (link.cfgSync == link.cfgPrev)
		begin
			next_link.cfg = link.cfgPrev;
		end
		next_link.muteMeta = ~txMute_n;
		next_link.muteSync = link.muteMeta;
		next_link.txWordValid = 1'b0;
		// Rising edge samples the pins directly, falling edge uses captures
		txNib = link.cfg.txCfg[PCFG_NEGEDGE_BIT] ? neg.txNibble : txNibbleBus;
		txPh = link.cfg.txCfg[PCFG_NEGEDGE_BIT] ? neg.txPhase : txWordPhase;
		txStrobeEff = (link.cfg.txCfg[PCFG_NEGEDGE_BIT] ? neg.strobe : gainStrobe)
			|| link.cfg.swStrobe;
		txGainMode = link.cfg.fullDuplex && link.cfg.gainOnTx && txStrobeEff && !txPh;
		txIsFirst = (txPh == link.cfg.txCfg[PCFG_PHASEINV_BIT]);
		txDataCycle = link.cfg.fullDuplex && !txGainMode;
		// Gain capture: two equal samples in a row form one stable clock
		next_link.gainRun = txGainMode;
		next_link.prevNibble = txNib;
		if (txGainMode && link.gainRun && (txNib == link.prevNibble))
		begin
			// Load only on a changed code, keeps toggles sparse
			if (!link.gainToggle == link.gainToggle || txNib != link.gainCapture)
			begin
				next_link.gainCapture = txNib;
				next_link.gainToggle = ~link.gainToggle;
			end
		end
		// Interpolator path
		if (txDataCycle)
		begin
			case (link.txState)
				NPGC_TX_IDLE,
				NPGC_TX_HAVE_FIRST:
				begin
					if (txIsFirst)
					begin
						// Repeated first level refreshes the nibble, word held
						next_link.firstNibble = txNib;
						next_link.txState = NPGC_TX_HAVE_FIRST;
					end
					else if (link.txState == NPGC_TX_HAVE_FIRST)
					begin
						next_link.txWord = link.muteSync ? 10'h000
							: fmtWord(joinNibbles(link.firstNibble, txNib,
							link.cfg.txCfg[PCFG_FIVE_BIT],
							link.cfg.txCfg[PCFG_LSFIRST_BIT]),
							link.cfg.txCfg[PCFG_BINARY_BIT]);
						next_link.txWordValid = 1'b1;
						next_link.txState = NPGC_TX_IDLE;
					end
				end
				default: next_link.txState = NPGC_TX_IDLE;
			endcase
		end
		else
		begin
			next_link.txState = NPGC_TX_IDLE;
		end
		// Receive side: phase toggles every nibble clock in full duplex
		if (link.cfg.fullDuplex)
		begin
			next_link.rxPhase = ~link.rxPhase;
			if (~link.rxPhase == link.cfg.rxCfg[PCFG_PHASEINV_BIT])
			begin
				// First nibble of a new word; word taken from the converter
				next_link.rxHold = fmtWord(rxSample, link.cfg.rxCfg[PCFG_BINARY_BIT]);
				next_link.rxNibble = splitNibble(next_link.rxHold,
					link.cfg.rxCfg[PCFG_FIVE_BIT],
					!link.cfg.rxCfg[PCFG_LSFIRST_BIT]);
			end
			else
			begin
				next_link.rxNibble = splitNibble(link.rxHold, link.cfg.rxCfg[PCFG_FIVE_BIT],
					link.cfg.rxCfg[PCFG_LSFIRST_BIT]);
			end
		end
		else
		begin
			next_link.rxPhase = 1'b0;
			next_link.rxNibble = 6'h00;
		end
		// Synchronous link reset, keeps its own synchroniser running
		if (linkReset)
		begin
			next_link = '0;
			next_link.rstSync = {link.rstSync[0], reset};
		end
	end

	// Link-domain flops
	always_ff @(posedge nibbleClk)
	begin
		link <= next_link;
	end

	// Outputs
	always_comb
	begin
		regRdata = sys.rdata;
		rxGainCode = sys.rxGain;
		txGainCode = sys.txGain;
		interpFactor = sys.txCfg[7:6];
		lowDrive = sys.drive[DRIVE_LOW_BIT];
		txWord = link.txWord;
		txWordValid = link.txWordValid;
		// Rx data launched on the selected edge
		rxNibbleBus = link.cfg.rxCfg[PCFG_NEGEDGE_BIT] ? neg.rxNibble : link.rxNibble;
		rxWordPhase = link.cfg.rxCfg[PCFG_NEGEDGE_BIT] ? neg.rxPhase : link.rxPhase;
		rxBusOe = link.cfg.fullDuplex && !link.cfg.rxCfg[PCFG_TRISTATE_BIT];
	end

	// Register-domain checks
	a_spi_gain_load: assert property (@(posedge clk_sys) disable iff (reset)
		spiGainWrite |=> rxGainCode == $past(spiGainValue))
		else $error("enabled gain write not loaded");
	a_spi_gain_hold: assert property (@(posedge clk_sys) disable iff (reset)
		(regWrite && regAddr == ADDR_RX_GAIN && !regWdata[GAIN_SPI_EN_BIT] && !gainEvent
		&& !sys.gainSrc[SRC_DIRECT_RX_BIT]) |=> $stable(rxGainCode))
		else $error("gain changed without enable bit");
	a_no_bypass: assert property (@(posedge clk_sys) disable iff (reset)
		(regWrite && regAddr == ADDR_TX_CFG && sys.fullDuplex)
		|=> (interpFactor != INTERP_X1) && (interpFactor != INTERP_RSVD))
		else $error("bypass accepted in full duplex");
	a_direct_pass: assert property (@(posedge clk_sys) disable iff (reset)
		(sys.gainSrc[SRC_DIRECT_RX_BIT] && !sys.gainSrc[SRC_MAP3_BIT] && !gainEvent
		&& !spiGainWrite) |=> rxGainCode == $past(sys.direct))
		else $error("direct gain not passed");
	a_coarse_floor: assert property (@(posedge clk_sys) disable iff (reset)
		(sys.gainSrc[SRC_DIRECT_RX_BIT] && sys.gainSrc[SRC_MAP3_BIT] && !gainEvent
		&& !spiGainWrite && sys.direct[5:4] == 2'h0) |=> rxGainCode == GAIN_MIN)
		else $error("coarse low codes not at floor");
	a_clock_off: assert property (@(posedge clk_sys) disable iff (reset)
		sys.portClk[PCLK_DISABLE_BIT] |-> !sharedPortClock)
		else $error("port clock not disabled");
	a_reset_gain: assert property (@(posedge clk_sys)
		reset |=> rxGainCode == GAIN_MIN)
		else $error("gain not minimum after reset");

	// Link-domain checks
	a_word_on_pair: assert property (@(posedge nibbleClk) disable iff (linkReset)
		(txDataCycle && link.txState == NPGC_TX_HAVE_FIRST && !txIsFirst) |=> txWordValid)
		else $error("word not formed after second nibble");
	a_valid_single: assert property (@(posedge nibbleClk) disable iff (linkReset)
		txWordValid |=> !txWordValid)
		else $error("words faster than half nibble rate");
	a_word_held: assert property (@(posedge nibbleClk) disable iff (linkReset)
		(txDataCycle && txIsFirst) |=> $stable(txWord))
		else $error("word changed on first level");
	a_rx_phase_run: assert property (@(posedge nibbleClk) disable iff (linkReset)
		(link.cfg.fullDuplex ##1 link.cfg.fullDuplex) |-> link.rxPhase != $past(link.rxPhase))
		else $error("rx phase did not toggle");

	// Main scenarios
	c_tx_word: cover property (@(posedge nibbleClk) disable iff (linkReset)
		txDataCycle ##1 txWordValid);
	c_gain_port: cover property (@(posedge clk_sys) disable iff (reset)
		gainEvent && sys.fullDuplex);
	c_rx_word: cover property (@(posedge nibbleClk) disable iff (linkReset)
		rxBusOe ##1 rxBusOe ##1 rxBusOe);

endmodule
`default_nettype wire

// file: shared/npgc_pkg.sv
// Constants, types and register map of the nibble port and gain control block.
package npgc_pkg;
	// Register offsets
	localparam logic [7:0] ADDR_PORT_CLOCK = 8'h05;
	localparam logic [7:0] ADDR_RX_GAIN = 8'h09;
	localparam logic [7:0] ADDR_GAIN_SRC = 8'h0b;
	localparam logic [7:0] ADDR_TX_CFG = 8'h0c;
	localparam logic [7:0] ADDR_RX_CFG = 8'h0d;
	localparam logic [7:0] ADDR_DRIVE = 8'h0e;
	// Reset values
	localparam logic [7:0] PORT_CLOCK_RESET = 8'h00;
	localparam logic [7:0] GAIN_SRC_RESET = 8'h04;
	localparam logic [7:0] PORT_CFG_RESET = 8'h00;
	localparam logic [7:0] DRIVE_RESET = 8'h00;
	localparam logic [5:0] GAIN_MIN = 6'h00;
	// Port clock control fields
	localparam int PCLK_DISABLE_BIT = 0;
	localparam int PCLK_INVERT_BIT = 1;
	localparam int PCLK_OSC_BIT = 2;
	localparam logic [7:0] PORT_CLOCK_MASK = 8'h07;
	// Gain register and gain source fields
	localparam int GAIN_SPI_EN_BIT = 6;
	localparam int SRC_MAP3_BIT = 1;
	localparam int SRC_TXPORT_BIT = 2;
	localparam int SRC_SWSTROBE_BIT = 3;
	localparam int SRC_DIRECT_RX_BIT = 5;
	localparam int SRC_DIRECT_TX_BIT = 6;
	// Tx/rx port configuration fields, then the low drive bit of the drive register
	localparam int PCFG_BINARY_BIT = 0;
	localparam int PCFG_NEGEDGE_BIT = 1;
	localparam int PCFG_LSFIRST_BIT = 2;
	localparam int PCFG_FIVE_BIT = 3;
	localparam int PCFG_PHASEINV_BIT = 4;
	localparam int PCFG_TRISTATE_BIT = 5;
	localparam int DRIVE_LOW_BIT = 7;
	// Interpolation factor codes in tx config bits 7:6
	localparam logic [1:0] INTERP_X1 = 2'h2;
	localparam logic [1:0] INTERP_RSVD = 2'h3;
	// Widths and format constant
	localparam int GAIN_W = 6;
	localparam int WORD_W = 10;
	localparam int NIB_W = 6;
	localparam logic [9:0] SIGN_FLIP = 10'h200;

	// Tx word assembly states
	typedef enum logic [0:0] {NPGC_TX_IDLE = 1'b0, NPGC_TX_HAVE_FIRST = 1'b1} npgc_tx_state_t;

	// Configuration handed from the register domain to the link domain
	typedef struct packed {
		logic fullDuplex;
		logic gainOnTx;
		logic swStrobe;
		logic [7:0] txCfg;
		logic [7:0] rxCfg;
	} npgc_link_cfg_t;

	// Register-domain state
	typedef struct packed {
		logic modeMeta;
		logic fullDuplex;
		logic [5:0] directMeta;
		logic [5:0] direct;
		logic togMeta;
		logic togSync;
		logic togSeen;
		logic [7:0] portClk;
		logic [7:0] gainSrc;
		logic [7:0] txCfg;
		logic [7:0] rxCfg;
		logic [7:0] drive;
		logic rxGainSpiEn;
		logic [5:0] rxGain;
		logic [5:0] txGain;
		logic [7:0] rdata;
	} npgc_sys_state_t;

	// Link-domain state
	typedef struct packed {
		logic [1:0] rstSync;
		npgc_link_cfg_t cfgMeta;
		npgc_link_cfg_t cfgSync;
		npgc_link_cfg_t cfgPrev;
		npgc_link_cfg_t cfg;
		logic muteMeta;
		logic muteSync;
		npgc_tx_state_t txState;
		logic [5:0] firstNibble;
		logic [9:0] txWord;
		logic txWordValid;
		logic gainRun;
		logic [5:0] prevNibble;
		logic [5:0] gainCapture;
		logic gainToggle;
		logic rxPhase;
		logic [9:0] rxHold;
		logic [5:0] rxNibble;
	} npgc_link_state_t;

	// Falling-edge capture and launch state
	typedef struct packed {
		logic [5:0] txNibble;
		logic txPhase;
		logic strobe;
		logic [5:0] rxNibble;
		logic rxPhase;
	} npgc_neg_state_t;
endpackage

// file: verification/nibble_port_gain_control_tb.sv
// Self-checking bench for the nibble port and its gain paths.
`timescale 1ns/1ps
`default_nettype none
`define CHECK(n, e, g) begin checksDone++; if ((g) !== (e)) begin numErrors++; \
	$display("BAD %s expected %h seen %h", n, e, g); end end
module nibble_port_gain_control_tb;
	import npgc_pkg::*;
	// Design pins
	logic clk_sys, reset, regWrite, regRead, modeSelect, nibbleClk, oscInput;
	logic [7:0] regAddr, regWdata, regRdata;
	logic sharedPortClock, txWordPhase, gainStrobe, txMute_n, rxBusOe, rxWordPhase;
	logic [5:0] txNibbleBus, rxNibbleBus, directGainBus, rxGainCode, txGainCode;
	logic [9:0] rxSample, txWord, rxWordSeen, expW;
	logic txWordValid, lowDrive, txArm, rxArm;
	logic [1:0] interpFactor;
	logic [31:0] rxCount;
	logic [31:0] seed = 32'hdb52;
	logic [9:0] txExp [$]; // Expected tx words, oldest first
	int numErrors = 0;
	int checksDone = 0;
	logic [7:0] regTab [7] = '{8'h05, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h07};
	logic [7:0] rstTab [7] = '{8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] clkTab [4] = '{8'h02, 8'h01, 8'h04, 8'h00};
	logic [7:0] modeTab [6] = '{8'h08, 8'h04, 8'h01, 8'h10, 8'h02, 8'h00};

	npgc_port uut (.clk_sys(clk_sys), .reset(reset), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .modeSelect(modeSelect),
		.nibbleClk(nibbleClk), .oscInput(oscInput), .sharedPortClock(sharedPortClock),
		.txNibbleBus(txNibbleBus), .txWordPhase(txWordPhase), .gainStrobe(gainStrobe),
		.txMute_n(txMute_n), .rxNibbleBus(rxNibbleBus), .rxBusOe(rxBusOe),
		.rxWordPhase(rxWordPhase), .directGainBus(directGainBus), .rxSample(rxSample),
		.txWord(txWord), .txWordValid(txWordValid), .rxGainCode(rxGainCode),
		.txGainCode(txGainCode), .interpFactor(interpFactor), .lowDrive(lowDrive));

	npgc_asic_model model (.portClk(sharedPortClock), .txBus(txNibbleBus),
		.txPhase(txWordPhase), .gainStrobe(gainStrobe), .rxBus(rxNibbleBus),
		.rxPhase(rxWordPhase), .rxWord(rxWordSeen), .rxCount(rxCount));

	// Clocks with offsets so no edges coincide with the sampling points
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial
	begin
		nibbleClk = 1'b0;
		#3;
		forever #7.5 nibbleClk = ~nibbleClk;
	end
	initial
	begin
		oscInput = 1'b0;
		#1;
		forever #12.5 oscInput = ~oscInput;
	end

	// Fixed-seed xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic regWr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge clk_sys);
		regWrite = 1'b0;
	endtask

	task automatic regRd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk_sys);
		regAddr = a;
		regRead = 1'b1;
		@(negedge clk_sys);
		regRead = 1'b0;
		`CHECK("regRdata", e, regRdata)
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checksDone, numErrors);
		if (numErrors == 0 && checksDone > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Tx watcher: while armed, every new word takes the oldest note; a spare word mismatches
	always @(posedge nibbleClk)
	begin
		if (txWordValid === 1'b1 && txArm)
		begin
			expW = (txExp.size() > 0) ? txExp.pop_front() : ~txWord;
			`CHECK("txWord", expW, txWord)
		end
	end

	// Rx watcher: while armed, each word the model rebuilds must equal the held sample
	always @(rxCount)
	begin
		if (rxArm)
			`CHECK("rxWord", rxSample, rxWordSeen)
	end

	// Hang guard
	initial
	begin
		#200000;
		numErrors++;
		conclude();
	end

	// Main sequence
	initial
	begin
		logic [7:0] c;
		logic [9:0] w;
		reset = 1'b1;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 8'h00;
		regWdata = 8'h00;
		modeSelect = 1'b1;
		txMute_n = 1'b1;
		directGainBus = 6'h00;
		rxSample = 10'h000;
		txArm = 1'b0;
		rxArm = 1'b0;
		repeat (10) @(posedge clk_sys);
		@(negedge clk_sys);
		reset = 1'b0;
		repeat (12) @(negedge clk_sys);
		`CHECK("rxGainCode", GAIN_MIN, rxGainCode)
		for (int i = 0; i < 7; i++)
			regRd(regTab[i], rstTab[i]);
		regWr(ADDR_RX_GAIN, 8'h45);
		`CHECK("rxGainCode", 6'h05, rxGainCode)
		regRd(ADDR_RX_GAIN, 8'h45);
		regWr(ADDR_RX_GAIN, 8'h0a);
		`CHECK("rxGainCode", 6'h05, rxGainCode)
		regRd(ADDR_RX_GAIN, 8'h00);
		regWr(ADDR_TX_CFG, 8'h80);
		`CHECK("interpFactor", 2'h0, interpFactor)
		regWr(ADDR_DRIVE, 8'h80);
		`CHECK("lowDrive", 1'b1, lowDrive)
		// Port clock: invert, disable, oscillator, default
		for (int i = 0; i < 4; i++)
		begin
			c = clkTab[i];
			regWr(ADDR_PORT_CLOCK, c);
			repeat (6)
			begin
				@(negedge clk_sys);
				w[0] = c[0] ? 1'b0 : ((c[2] ? oscInput : nibbleClk) ^ c[1]);
				`CHECK("sharedPortClock", w[0], sharedPortClock)
			end
		end
		// Tx words in every port format, back to back, then idle
		for (int m = 0; m < 6; m++)
		begin
			c = modeTab[m];
			txArm = 1'b0;
			regWr(ADDR_TX_CFG, c);
			repeat (8) @(negedge clk_sys);
			model.rest(c);
			txArm = 1'b1;
			repeat (6)
			begin
				w = 10'(rnd());
				txExp.push_back(w);
				model.sendWord(w, c);
			end
			model.rest(c);
			repeat (4) @(negedge clk_sys);
			`CHECK("txPending", 0, txExp.size())
		end
		// Muted transmit gives silent words
		txMute_n = 1'b0;
		repeat (4) @(negedge clk_sys);
		txExp.push_back(10'h000);
		model.sendWord(10'(rnd()), 8'h00);
		model.rest(8'h00);
		txMute_n = 1'b1;
		// Gain through the tx port, pin strobe then software strobe
		txArm = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			if (i == 2)
				regWr(ADDR_GAIN_SRC, 8'h0c);
			w = 10'(i * 13 + 3);
			model.sendGain(w[5:0], i < 2);
			repeat (12) @(negedge clk_sys);
			`CHECK("rxGainCode", w[5:0], rxGainCode)
		end
		// Direct gain bus to either target, then the coarse map
		regWr(ADDR_GAIN_SRC, 8'h20);
		directGainBus = 6'(rnd());
		repeat (6) @(negedge clk_sys);
		`CHECK("rxGainCode", directGainBus, rxGainCode)
		regWr(ADDR_GAIN_SRC, 8'h40);
		directGainBus = 6'(rnd());
		repeat (6) @(negedge clk_sys);
		`CHECK("txGainCode", directGainBus, txGainCode)
		regWr(ADDR_GAIN_SRC, 8'h22);
		for (int k = 0; k < 8; k++)
		begin
			directGainBus = {3'(k), 3'(rnd())};
			repeat (6) @(negedge clk_sys);
			`CHECK("rxGainCode", (k < 2) ? 6'h00 : 6'((k - 1) * 8), rxGainCode)
		end
		// Rx words against held samples in every rx port format
		for (int k = 0; k < 6; k++)
		begin
			c = modeTab[k];
			regWr(ADDR_RX_CFG, c);
			model.rxCfg = c;
			rxSample = 10'(rnd());
			repeat (10) @(negedge clk_sys);
			rxArm = 1'b1;
			repeat (10) @(negedge clk_sys);
			rxArm = 1'b0;
			`CHECK("rxBusOe", 1'b1, rxBusOe)
		end
		// Three-state setting releases the rx bus
		regWr(ADDR_RX_CFG, 8'h20);
		repeat (8) @(negedge clk_sys);
		`CHECK("rxBusOe", 1'b0, rxBusOe)
		conclude();
	end
endmodule
`undef CHECK
`default_nettype wire

// file: verification/npgc_asic_model.sv
// Back-end model at the far side of the nibble port.
`timescale 1ns/1ps
`default_nettype none
module npgc_asic_model
	import npgc_pkg::*;
(
	// Port clock from the device
	input wire logic portClk,
	// Tx nibble side
	output logic [5:0] txBus,
	output logic txPhase,
	output logic gainStrobe,
	// Rx nibble side
	input wire logic [5:0] rxBus,
	input wire logic rxPhase,
	output logic [9:0] rxWord,
	output logic [31:0] rxCount
);
	logic [5:0] rxFirst; // Held first nibble of a word
	logic [7:0] rxCfg = 8'h00; // Rx port settings, mirrored by the bench

	// Quiet bus at time zero
	initial
	begin
		txBus = 6'h00;
		txPhase = 1'b0;
		gainStrobe = 1'b0;
		rxCount = 0;
	end

	// One word as two nibbles; unused lines carry junk on purpose
	task automatic sendWord(input logic [9:0] w, input logic [7:0] cfg);
		logic [9:0] s;
		logic [5:0] ms;
		logic [5:0] ls;
		s = cfg[PCFG_BINARY_BIT] ? (w ^ SIGN_FLIP) : w;
		ms = cfg[PCFG_FIVE_BIT] ? {s[9:5], ~s[5]} : s[9:4];
		ls = cfg[PCFG_FIVE_BIT] ? {s[4:0], ~s[0]} : {~s[3:2], s[3:0]};
		@(negedge portClk);
		txPhase <= cfg[PCFG_PHASEINV_BIT];
		txBus <= cfg[PCFG_LSFIRST_BIT] ? ls : ms;
		@(negedge portClk);
		txPhase <= ~cfg[PCFG_PHASEINV_BIT];
		txBus <= cfg[PCFG_LSFIRST_BIT] ? ms : ls;
	endtask

	// Idle at the first-nibble level, zeros on the bus
	task automatic rest(input logic [7:0] cfg);
		@(negedge portClk);
		txPhase <= cfg[PCFG_PHASEINV_BIT];
		txBus <= 6'h00;
		repeat (4) @(negedge portClk);
	endtask

	// Gain code held with phase low for several clocks; bus left stable after
	task automatic sendGain(input logic [5:0] g, input logic strobe);
		@(negedge portClk);
		txPhase <= 1'b0;
		txBus <= g;
		gainStrobe <= strobe;
		repeat (3) @(negedge portClk);
		gainStrobe <= 1'b0;
	endtask

	// Rebuild an rx word from its first and second nibble per rxCfg
	function automatic logic [9:0] joinRx(input logic [5:0] first, input logic [5:0] second);
		logic [5:0] ms;
		logic [5:0] ls;
		logic [9:0] w;
		ms = rxCfg[PCFG_LSFIRST_BIT] ? second : first;
		ls = rxCfg[PCFG_LSFIRST_BIT] ? first : second;
		w = rxCfg[PCFG_FIVE_BIT] ? {ms[5:1], ls[5:1]} : {ms, ls[3:0]};
		return rxCfg[PCFG_BINARY_BIT] ? (w ^ SIGN_FLIP) : w;
	endfunction

	// Rx words: first nibble on the configured first level, second on the next
	always @(posedge portClk)
	begin
		if (rxPhase == rxCfg[PCFG_PHASEINV_BIT])
			rxFirst <= rxBus;
		else
		begin
			rxWord <= joinRx(rxFirst, rxBus);
			rxCount <= rxCount + 1;
		end
	end
endmodule
`default_nettype wire
